// file: design/lnc_band_filter.sv
/*
 selectable band filter on five luma taps, centre at tap 2.
 assumes taps are presented as {newest ... oldest}; purely combinational.
*/
`timescale 1ns/1ps
module lnc_band_filter import lnc_pkg::*; (
   input wire logic [2:0] sel,
   input wire logic [39:0] taps,
   output logic signed [10:0] hp
);
   logic signed [11:0] t0, t1, t2, t3, t4;
   logic signed [11:0] acc;

   assign t0 = $signed({4'h0, taps[39:32]});
   assign t1 = $signed({4'h0, taps[31:24]});
   assign t2 = $signed({4'h0, taps[23:16]});
   assign t3 = $signed({4'h0, taps[15:8]});
   assign t4 = $signed({4'h0, taps[7:0]});

   // only the selected passband reaches coring or boosting
   always_comb begin
      case (sel)
         3'h0: acc = 12'((2 * t2 - t1 - t3) >>> 1);
         3'h1: acc = 12'(2 * t2 - t1 - t3);
         3'h2: acc = 12'((2 * t2 - t0 - t4) >>> 1);
         3'h3: acc = 12'(2 * t2 - t0 - t4);
         3'h4: acc = 12'((4 * t2 - t1 - t3 - t0 - t4) >>> 2);
         3'h5: acc = 12'((4 * t2 - t1 - t3 - t0 - t4) >>> 1);
         3'h6: acc = 12'(t2 - t3);
         default: acc = 12'((t3 - t1) >>> 1);
      endcase
   end

   assign hp = acc[10:0];
endmodule

// file: design/lnc_luma_noise_coring.sv
/*
 luma noise coring stage: band filter on luma, threshold compare, coring or boosting with
 separate gains at block borders and inside blocks; chroma passes untouched.
 assumes an interleaved 4:2:2 sample stream marked by inValid, one sample per valid
 cycle, two samples per pixel, lineStart flagging the first sample of each line.
*/
`timescale 1ns/1ps
`include "lnc_map.svh"
module lnc_luma_noise_coring import lnc_pkg::*; #(
   parameter int CNT_W = 11,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire lnc_sample_t inSample,
   input wire logic inValid,
   input wire logic lineStart,
   output lnc_sample_t outSample,
   output logic outValid
);
   lnc_cfg_t cfg;
   lnc_status_t status;
   lnc_sample_t dly [DEPTH];
   logic [7:0] lumaHist [DEPTH];
   logic [CNT_W-1:0] lumaCnt, curIdx, centreIdx;
   logic [4:0] blockSize, half, pos;
   logic border;
   logic [3:0] gainSel, factor;
   logic signed [10:0] hp;
   logic [10:0] absHp;
   logic signed [15:0] prod, delta, sum;
   logic apply, takeLuma;
   logic [7:0] centre, next_luma;

   lnc_wb_regs u_regs (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .status(status),
      .cfg(cfg)
   );

   // taps: incoming luma plus four earlier ones; centre is two lumas back
   lnc_band_filter u_filt (
      .sel(cfg.filtSel),
      .taps({inSample.data, lumaHist[0], lumaHist[1], lumaHist[2], lumaHist[3]}),
      .hp(hp)
   );

   assign takeLuma = ce && inValid && inSample.isLuma;
   assign centre = lumaHist[1];

   // sample delay line, same depth for chroma and luma so latency never varies
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_dly
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               dly[i] <= '0;
               lumaHist[i] <= 8'h00;
            end else begin
               if (ce && inValid) begin
                  dly[i] <= (i == 0) ? inSample : dly[(i == 0) ? 0 : i - 1];
               end
               if (takeLuma) begin
                  lumaHist[i] <= (i == 0) ? inSample.data : lumaHist[(i == 0) ? 0 : i - 1];
               end
            end
         end
      end
   endgenerate

   // pixel index within the line, counted once per luma, i.e. per two samples
   assign curIdx = lineStart ? '0 : lumaCnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lumaCnt <= '0;
      end else if (ce && inValid) begin
         if (inSample.isLuma) begin
            lumaCnt <= curIdx + 1'b1;
         end else if (lineStart) begin
            lumaCnt <= '0;
         end
      end
   end

   // block position of the centre pixel, data shifted by the offset
   assign centreIdx = curIdx - `LNC_CENTRE_LAG;
   assign blockSize = cfg.blockLarge ? `LNC_BLOCK_LARGE : `LNC_BLOCK_SMALL;
   assign half = cfg.borderWide ? `LNC_HALF_WIDE : `LNC_HALF_NARROW;
   assign pos = (centreIdx[4:0] + {1'b0, cfg.offset}) & (blockSize - 5'h01);
   assign border = (pos < half) || (pos >= blockSize - half);
   assign gainSel = border ? cfg.gainBorder : cfg.gainData;

   // codes above the top step saturate at 1 (noise) or 1/2 (sharpness)
   assign factor = (gainSel > `LNC_GAIN_MAX) ? `LNC_GAIN_MAX : gainSel;
   assign absHp = hp[10] ? 11'(-hp) : hp;
   assign prod = 16'(hp * $signed({1'b0, factor}));

   always_comb begin
      if (cfg.sharpMode) begin
         delta = prod >>> `LNC_SHARP_SHIFT;
         apply = absHp > {5'h00, cfg.thr};
         sum = $signed({8'h00, centre}) + delta;
      end else begin
         delta = prod >>> `LNC_NOISE_SHIFT;
         apply = absHp < {5'h00, cfg.thr};
         sum = $signed({8'h00, centre}) - delta;
      end
      if (!apply || factor == 4'h0) begin
         next_luma = centre;
      end else if (sum < 0) begin
         next_luma = 8'h00;
      end else if (sum > $signed({8'h00, `LNC_LUMA_MAX})) begin
         next_luma = `LNC_LUMA_MAX;
      end else begin
         next_luma = sum[7:0];
      end
   end

   // output register: luma replaced, chroma copied from the tail
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outSample <= '0;
         outValid <= 1'b0;
      end else if (ce) begin
         outValid <= inValid;
         if (inValid) begin
            outSample.isLuma <= dly[DEPTH-1].isLuma;
            outSample.data <= dly[DEPTH-1].isLuma && takeLuma ? next_luma
                              : dly[DEPTH-1].data;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else if (takeLuma) begin
         status.pos <= pos[3:0];
         status.border <= border;
         status.altered <= next_luma != centre;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_CHROMA_BYPASS: assert property (
      ce && inValid && !dly[DEPTH-1].isLuma
      |=> outValid && !outSample.isLuma && outSample.data == $past(dly[DEPTH-1].data))
      else $error("chroma sample altered");
   AST_ZERO_GAIN: assert property (
      takeLuma && factor == 4'h0 |=> outValid && outSample.data == $past(centre))
      else $error("zero gain changed luma");
   AST_NOISE_ABOVE_THR: assert property (
      takeLuma && !cfg.sharpMode && absHp >= {5'h00, cfg.thr}
      |=> outSample.data == $past(centre))
      else $error("noise mode touched signal above threshold");
   AST_NOISE_SUBTRACT: assert property (
      takeLuma && !cfg.sharpMode && absHp < {5'h00, cfg.thr} && hp >= 11'sd8
      && factor == `LNC_GAIN_MAX && centre >= 8'h10
      |=> outSample.data < $past(centre))
      else $error("noise not subtracted");
   AST_SHARP_BELOW_THR: assert property (
      takeLuma && cfg.sharpMode && absHp <= {5'h00, cfg.thr}
      |=> outSample.data == $past(centre))
      else $error("sharpness mode boosted noise");
   AST_SHARP_ADD: assert property (
      takeLuma && cfg.sharpMode && absHp > {5'h00, cfg.thr} && hp >= 11'sd16
      && factor == `LNC_GAIN_MAX && centre < 8'hc8
      |=> outSample.data > $past(centre))
      else $error("valid signal not boosted");
   AST_BORDER_GAIN: assert property (
      takeLuma && (pos == 5'h00 || pos == blockSize - 5'h01) |-> gainSel == cfg.gainBorder)
      else $error("border pixel used data gain");
   AST_DATA_GAIN: assert property (
      takeLuma && pos == (blockSize >> 1) |-> gainSel == cfg.gainData)
      else $error("inner pixel used border gain");
   AST_WIDE_BORDER: assert property (
      takeLuma && cfg.borderWide && pos == 5'h01 |-> border)
      else $error("wide border missing second pixel");
   AST_POS_RANGE: assert property (
      takeLuma |-> pos < blockSize)
      else $error("block position outside block");
   AST_PIX_COUNT: assert property (
      ce && inValid && !inSample.isLuma && !lineStart |=> lumaCnt == $past(lumaCnt))
      else $error("pixel count moved on chroma sample");
   AST_FIXED_LATENCY: assert property (
      ce && inValid |=> outValid)
      else $error("output not produced at fixed latency");

   // pixel counting along the line
   AST_PIX_STEP: assert property (
      ce && inValid && inSample.isLuma && !lineStart
      |=> lumaCnt == CNT_W'($past(lumaCnt) + 1'b1))
      else $error("pixel count did not advance on luma");
   AST_LINE_RESTART: assert property (
      ce && inValid && lineStart
      |=> lumaCnt == CNT_W'($past(inSample.isLuma)))
      else $error("pixel count not restarted at line start");

   // block geometry and border placement
   AST_NARROW_BORDER: assert property (
      takeLuma && !cfg.borderWide && pos == 5'h01
      |-> !border)
      else $error("narrow border spans two pixels");
   AST_WIDE_BORDER_END: assert property (
      takeLuma && cfg.borderWide && pos == blockSize - 5'h02
      |-> border)
      else $error("wide border missing its closing pixels");
   AST_SMALL_BLOCK_END: assert property (
      takeLuma && !cfg.blockLarge && pos == `LNC_BLOCK_SMALL - 5'h01
      |-> border && gainSel == cfg.gainBorder)
      else $error("last pixel of small block not a border");
   AST_LARGE_BLOCK_MID: assert property (
      takeLuma && cfg.blockLarge && pos == `LNC_BLOCK_SMALL - 5'h01
      |-> !border && gainSel == cfg.gainData)
      else $error("inside of large block treated as border");
   AST_STATUS_TRACK: assert property (
      takeLuma
      |=> status.pos == $past(pos[3:0]) && status.border == $past(border))
      else $error("status does not follow block position");

   // threshold and direction of the correction in each mode, gain saturation, zero-gain status, luma marker and output hold
   AST_THR_EQUAL: assert property (
      takeLuma && absHp == {5'h00, cfg.thr}
      |=> outSample.data == $past(centre))
      else $error("luma changed at threshold level");
   AST_NOISE_NO_ADD: assert property (
      takeLuma && !cfg.sharpMode && hp > 11'sd0
      |=> outSample.data <= $past(centre))
      else $error("noise mode raised luma on positive band output");
   AST_SHARP_NO_CUT: assert property (
      takeLuma && cfg.sharpMode && hp > 11'sd0
      |=> outSample.data >= $past(centre))
      else $error("sharpness mode lowered luma on positive band output");
   AST_NOISE_NEG: assert property (
      takeLuma && dly[DEPTH-1].isLuma && !cfg.sharpMode && absHp < {5'h00, cfg.thr}
      && hp <= -11'sd8 && factor == `LNC_GAIN_MAX && centre < 8'hf0
      |=> outSample.data > $past(centre))
      else $error("negative noise not removed");
   AST_SHARP_NEG: assert property (
      takeLuma && dly[DEPTH-1].isLuma && cfg.sharpMode && absHp > {5'h00, cfg.thr}
      && hp <= -11'sd16 && factor == `LNC_GAIN_MAX && centre >= 8'h10
      |=> outSample.data < $past(centre))
      else $error("negative edge not boosted");
   AST_GAIN_SAT: assert property (
      takeLuma && gainSel > `LNC_GAIN_MAX
      |-> factor == `LNC_GAIN_MAX)
      else $error("gain code above top step not saturated");
   AST_ZERO_NOT_ALTERED: assert property (
      takeLuma && factor == 4'h0
      |=> !status.altered)
      else $error("status reports change at zero gain");
   AST_LUMA_FLAG: assert property (
      ce && inValid && dly[DEPTH-1].isLuma
      |=> outValid && outSample.isLuma)
      else $error("luma sample lost its marker");
   AST_OUT_HOLD: assert property (
      ce && !inValid
      |=> !outValid && $stable(outSample))
      else $error("output moved without an input sample");

   CV_SHARP_BOOST: cover property (takeLuma && cfg.sharpMode && apply && factor != 4'h0);
   CV_NOISE_CORE: cover property (takeLuma && !cfg.sharpMode && apply && factor != 4'h0);
   CV_WIDE_BORDER_LARGE: cover property (takeLuma && border && cfg.borderWide
      && cfg.blockLarge);
   CV_OFFSET_SHIFT: cover property (takeLuma && cfg.offset == 4'hf && border);
   CV_CE_STALL: cover property (wb_cyc_i && wb_stb_i && !ce);
endmodule

// file: design/lnc_map.svh
/*
 luma noise coring: register indices, field positions, reset values and fixed figures.
 assumes inclusion by bare name from design files; definitions only.
*/
`ifndef LNC_MAP_SVH
`define LNC_MAP_SVH

// register indices; byte address is four times the index
`define LNC_IDX_GAINS 10'h0a3
`define LNC_IDX_THR_BLOCK 10'h0a4
`define LNC_IDX_FILT_MODE 10'h0a5
`define LNC_IDX_STATUS 10'h0a6

// field positions
`define LNC_GAIN_BORDER_MSB 3
`define LNC_GAIN_BORDER_LSB 0
`define LNC_GAIN_DATA_MSB 7
`define LNC_GAIN_DATA_LSB 4
`define LNC_THR_MSB 5
`define LNC_THR_LSB 0
`define LNC_BORDER_WIDE_BIT 6
`define LNC_BLOCK_LARGE_BIT 7
`define LNC_FILT_SEL_MSB 2
`define LNC_FILT_SEL_LSB 0
`define LNC_SHARP_MODE_BIT 4
`define LNC_OFFSET_MSB 7
`define LNC_OFFSET_LSB 4

// reset values
`define LNC_RST_GAINS 8'h00
`define LNC_RST_THR_BLOCK 8'h00
`define LNC_RST_FILT_MODE 8'h00

// gain scaling: noise steps of 1/8 up to 1, sharpness steps of 1/16 up to 1/2
`define LNC_GAIN_MAX 4'h8
`define LNC_NOISE_SHIFT 3
`define LNC_SHARP_SHIFT 4

// block geometry in pixels, one pixel being two samples
`define LNC_BLOCK_SMALL 5'h08
`define LNC_BLOCK_LARGE 5'h10
`define LNC_HALF_NARROW 5'h01
`define LNC_HALF_WIDE 5'h02

// luma taps behind the centre tap, and largest luma value
`define LNC_CENTRE_LAG 11'h002
`define LNC_LUMA_MAX 8'hff

`endif

// file: design/lnc_pkg.sv
/*
 luma noise coring: shared types.
 assumes lnc_map.svh supplies the numeric constants.
*/
package lnc_pkg;

   typedef struct packed {
      logic [7:0] data;
      logic isLuma;
   } lnc_sample_t;

   typedef struct packed {
      logic [3:0] gainData;
      logic [3:0] gainBorder;
      logic blockLarge;
      logic borderWide;
      logic [5:0] thr;
      logic [3:0] offset;
      logic sharpMode;
      logic [2:0] filtSel;
   } lnc_cfg_t;

   typedef struct packed {
      logic [3:0] pos;
      logic border;
      logic altered;
   } lnc_status_t;

endpackage

// file: design/lnc_wb_regs.sv
/*
 classic wishbone slave holding the three coring registers and a status word.
 assumes 32-bit data, word-aligned byte addresses, one master, one clock.
*/
`timescale 1ns/1ps
`include "lnc_map.svh"
module lnc_wb_regs import lnc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire lnc_status_t status,
   output lnc_cfg_t cfg
);
   logic [7:0] gains, thrBlock, filtMode;
   logic req;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gains <= `LNC_RST_GAINS;
         thrBlock <= `LNC_RST_THR_BLOCK;
         filtMode <= `LNC_RST_FILT_MODE;
      end else if (ce && req && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i[11:2])
            `LNC_IDX_GAINS: gains <= wb_dat_i[7:0];
            `LNC_IDX_THR_BLOCK: thrBlock <= wb_dat_i[7:0];
            `LNC_IDX_FILT_MODE: filtMode <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (ce && req) begin
         case (wb_adr_i[11:2])
            `LNC_IDX_GAINS: wb_dat_o <= {24'h00_0000, gains};
            `LNC_IDX_THR_BLOCK: wb_dat_o <= {24'h00_0000, thrBlock};
            `LNC_IDX_FILT_MODE: wb_dat_o <= {24'h00_0000, filtMode};
            `LNC_IDX_STATUS: wb_dat_o <= {26'h000_0000, status};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      cfg.gainBorder = gains[`LNC_GAIN_BORDER_MSB:`LNC_GAIN_BORDER_LSB];
      cfg.gainData = gains[`LNC_GAIN_DATA_MSB:`LNC_GAIN_DATA_LSB];
      cfg.thr = thrBlock[`LNC_THR_MSB:`LNC_THR_LSB];
      cfg.borderWide = thrBlock[`LNC_BORDER_WIDE_BIT];
      cfg.blockLarge = thrBlock[`LNC_BLOCK_LARGE_BIT];
      cfg.filtSel = filtMode[`LNC_FILT_SEL_MSB:`LNC_FILT_SEL_LSB];
      cfg.sharpMode = filtMode[`LNC_SHARP_MODE_BIT];
      cfg.offset = filtMode[`LNC_OFFSET_MSB:`LNC_OFFSET_LSB];
   end

   AST_WB_ACK_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
      wb_ack_o && ce |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_WB_GAIN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      ce && req && wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == `LNC_IDX_GAINS
      |=> cfg.gainBorder == $past(wb_dat_i[3:0]) && wb_ack_o)
      else $error("gain write not stored");
endmodule

// file: testbench/lnc_src_model.sv
/*
 upstream sample source: interleaved chroma/luma pixels, one line per call.
 assumes the bench calls send_line after reset; drives only just after rising edges.
*/
`timescale 1ns/1ps
module lnc_src_model import lnc_pkg::*; (
   input wire logic clk,
   output lnc_sample_t inSample,
   output logic inValid,
   output logic lineStart
);
   initial begin
      inSample = '0;
      inValid = 1'b0;
      lineStart = 1'b0;
   end
   // slow inserts an idle cycle after every sample
   task automatic send_line(input int n, input bit slow);
      for (int s = 0; s < 2 * n; s++) begin
         @(posedge clk);
         inValid <= 1'b1;
         lineStart <= (s == 0);
         // chroma then luma, two samples per pixel
         inSample.isLuma <= s[0];
         inSample.data <= s[0] ? 8'((s / 2 * 53 + 17) % 200 + 20) : 8'(8'h40 + s / 2);
         if (slow) begin
            @(posedge clk);
            inValid <= 1'b0;
            lineStart <= 1'b0;
            inSample.data <= ~inSample.data;
         end
      end
      @(posedge clk);
      inValid <= 1'b0;
      lineStart <= 1'b0;
      inSample.data <= ~inSample.data;
   endtask
endmodule

// file: testbench/sd_luma_noise_coring_test.sv
/*
 self-checking bench for the luma coring stage: wishbone register access and sample stream.
 assumes the source model drives the stream; expected luma is computed here per pixel.
*/
`timescale 1ns/1ps
module sd_luma_noise_coring_test import lnc_pkg::*;;
   logic clk, rst_n, ce, wbCyc, wbStb, wbWe, wbAck, outValid, inValid, lineStart;
   logic [11:0] wbAdr;
   logic [31:0] wbDat, wbDatO;
   logic [3:0] wbSel;
   lnc_sample_t inSample, outSample;
   lnc_sample_t outQ[$];
   int nMismatch = 0;
   int cmpCount = 0;
   int ackLat = 2;

   lnc_luma_noise_coring dut (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .inSample(inSample), .inValid(inValid),
      .lineStart(lineStart), .outSample(outSample), .outValid(outValid));
   lnc_src_model src (.clk(clk), .inSample(inSample), .inValid(inValid),
      .lineStart(lineStart));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (outValid === 1'b1) begin
         outQ.push_back(outSample);
      end
   end

   task automatic test_done();
      if (nMismatch == 0 && cmpCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nMismatch++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic wb_cycle(input logic [9:0] idx, input logic we, input logic [7:0] wd,
                           output logic [31:0] rd);
      int t;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {idx, 2'b00};
      wbDat <= {24'h000000, wd};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (wbAck !== 1'b1);
      rd = wbDatO;
      check(t, ackLat);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask

   function automatic int yAt(input int i);
      return (i * 53 + 17) % 200 + 20;
   endfunction
   function automatic logic [7:0] refLuma(input int i, input logic [7:0] gn, tb, fm);
      int c, l1, r1, l2, r2, hp, g, sz, half, pos, y, mag, thr;
      c = yAt(i);
      l1 = yAt(i + 1);
      r1 = yAt(i - 1);
      l2 = yAt(i + 2);
      r2 = yAt(i - 2);
      case (fm[2:0])
         3'h0: hp = (2 * c - l1 - r1) >>> 1;
         3'h1: hp = 2 * c - l1 - r1;
         3'h2: hp = (2 * c - l2 - r2) >>> 1;
         3'h3: hp = 2 * c - l2 - r2;
         3'h4: hp = (4 * c - l1 - r1 - l2 - r2) >>> 2;
         3'h5: hp = (4 * c - l1 - r1 - l2 - r2) >>> 1;
         3'h6: hp = c - r1;
         default: hp = (r1 - l1) >>> 1;
      endcase
      sz = tb[7] ? 16 : 8;
      half = tb[6] ? 2 : 1;
      pos = (i + int'(fm[7:4])) % sz;
      g = (pos < half || pos >= sz - half) ? int'(gn[3:0]) : int'(gn[7:4]);
      g = (g > 8) ? 8 : g;
      mag = (hp < 0) ? -hp : hp;
      thr = int'(tb[5:0]);
      y = c;
      if (!fm[4] && mag < thr) y = c - ((hp * g) >>> 3);
      if (fm[4] && mag > thr) y = c + ((hp * g) >>> 4);
      y = (y < 0) ? 0 : ((y > 255) ? 255 : y);
      return 8'(y);
   endfunction

   // reset, program and read back, stream one line, compare outputs from the fifth on, luma from pixel 2 on
   task automatic run_case(input logic [7:0] gn, tb, fm, input int n, input bit slow);
      logic [31:0] rd;
      int s;
      int i, sz, hf, p;
      logic bd, alt;
      do_reset();
      outQ.delete();
      wb_cycle(10'h0a3, 1'b1, gn, rd);
      wb_cycle(10'h0a4, 1'b1, tb, rd);
      wb_cycle(10'h0a5, 1'b1, fm, rd);
      wb_cycle(10'h0a3, 1'b0, 8'h00, rd);
      check(rd, {24'h0, gn});
      wb_cycle(10'h0a4, 1'b0, 8'h00, rd);
      check(rd, {24'h0, tb});
      wb_cycle(10'h0a5, 1'b0, 8'h00, rd);
      check(rd, {24'h0, fm});
      src.send_line(n, slow);
      repeat (3) @(posedge clk);
      check(outQ.size(), 2 * n);
      for (int j = 4; j < outQ.size(); j++) begin
         s = j - 4;
         if (!s[0]) begin
            check({23'h0, outQ[j]}, {23'h0, 8'(8'h40 + s / 2), 1'b0});
         end else if (s / 2 >= 2) begin
            check({23'h0, outQ[j]}, {23'h0, refLuma(s / 2, gn, tb, fm), 1'b1});
         end
      end
      // status holds position and outcome of the last centre pixel
      i = n - 3;
      sz = tb[7] ? 16 : 8;
      hf = tb[6] ? 2 : 1;
      p = (i + int'(fm[7:4])) % sz;
      bd = p < hf || p >= sz - hf;
      alt = refLuma(i, gn, tb, fm) != 8'(yAt(i));
      wb_cycle(10'h0a6, 1'b0, 8'h00, rd);
      check(rd, {26'h0, 4'(p), bd, alt});
   endtask

   task automatic sc_regs();
      logic [31:0] rd;
      do_reset();
      wb_cycle(10'h0a3, 1'b0, 8'h00, rd);
      check(rd, 32'h0);
      wb_cycle(10'h0a5, 1'b0, 8'h00, rd);
      check(rd, 32'h0);
      wbSel <= 4'he;
      wb_cycle(10'h0a3, 1'b1, 8'h77, rd);
      wbSel <= 4'hf;
      wb_cycle(10'h0a3, 1'b0, 8'h00, rd);
      check(rd, 32'h0);
      wb_cycle(10'h010, 1'b1, 8'h5a, rd);
      wb_cycle(10'h010, 1'b0, 8'h00, rd);
      check(rd, 32'h0);
   endtask
   // clock enable low stalls the bus answer; the write lands once it is high again
   task automatic sc_ce();
      logic [31:0] rd;
      do_reset();
      ackLat = 6;
      fork
         wb_cycle(10'h0a4, 1'b1, 8'h9c, rd);
         begin
            @(posedge clk);
            ce <= 1'b0;
            repeat (4) @(posedge clk);
            ce <= 1'b1;
         end
      join
      ackLat = 2;
      wb_cycle(10'h0a4, 1'b0, 8'h00, rd);
      check(rd, 32'h0000_009c);
   endtask
   task automatic sc_passthrough();
      run_case(8'h00, 8'h3f, 8'h01, 20, 1'b1);
   endtask
   task automatic sc_noise_filters();
      for (int f = 0; f < 8; f++) begin
         run_case(8'h85, 8'h3f, 8'(f), 12, 1'b0);
      end
   endtask
   task automatic sc_sharp();
      run_case(8'h4c, 8'h05, 8'h11, 20, 1'b0);
      run_case(8'hf8, 8'h28, 8'h35, 20, 1'b1);
   endtask
   task automatic sc_blocks();
      run_case(8'h08, 8'hff, 8'he1, 40, 1'b0);
      run_case(8'h30, 8'h7f, 8'h60, 24, 1'b0);
      run_case(8'h80, 8'hbf, 8'h21, 36, 1'b0);
   endtask

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 12'h000;
      wbDat = 32'h0;
      wbSel = 4'hf;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      sc_regs();
      sc_passthrough();
      sc_noise_filters();
      sc_sharp();
      sc_blocks();
      sc_ce();
      test_done();
   end
   initial begin
      #500000;
      nMismatch++;
      test_done();
   end
endmodule
